// [rtl/noc_core.v]
// Purpose: Numerically controlled oscillator with its control registers
// Assumes: sys_clk at 100 MHz; selected input clocks are much slower than sys_clk
// Notes: Pin, cell and fast sources become one-cycle tick enables on sys_clk; system source ticks every cycle
`timescale 1ns/1ps
`include "noc_regs.vh"

// What this block does
// RULE1: Pulse length is two to the width field
// RULE2: Clock field picks pin, cell, system, fast
// RULE3: Width field used only in pulsed mode
// RULE4: Software keeps width below overflow period
// RULE5: Polarity bit four, applied last, resets zero
// RULE6: Unused control, clock bits read zero
// RULE7: Low, high bytes access accumulator bits
// RULE8: Each input tick adds increment to accumulator, except in a cycle with an accumulator byte write
// RULE9: Mode bit picks pulsed or toggling output
// RULE10: Output level bit reads live output
// RULE11: Reset clears every oscillator register
// RULE12: Bit seven enables, bit six drives pin
module noc_core (
  input wire sys_clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire external_clock_pin,
  input wire logic_cell_output,
  output reg osc_out,
  output reg overflow_pulse,
  output reg pin_out,
  output reg pin_oe_n
);

  // ==========================================
  // Pulse length minus one for a width code
  function [6:0] noc_pulse_last;
    input [2:0] pws;
    reg [7:0] len;
    begin
      len = 8'h01 << pws;
      noc_pulse_last = len[6:0] - 7'h01;
    end
  endfunction

  // Write strobe aimed at one register offset
  function noc_wr_hit;
    input wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      noc_wr_hit = wr && (addr == ofs);
    end
  endfunction

  // ==========================================
  // Software-visible state
  reg module_enable_bit_r;
  reg pin_output_enable_r;
  reg output_polarity_bit_r;
  reg pulse_mode_select_r;
  reg [2:0] pulse_width_select_r;
  reg [1:0] clock_source_select_r;
  reg [19:0] phase_accumulator_r;
  reg [15:0] phase_increment_r;

  // ==========================================
  // Internal state
  reg ext_sync1_r;
  reg ext_sync2_r;
  reg ext_prev_r;
  reg cell_sync1_r;
  reg cell_sync2_r;
  reg cell_prev_r;
  reg [`NOC_HF_PH_W-1:0] hf_phase_r;
  reg hf_tick_r;
  reg active_r;
  reg [6:0] pulse_cnt_r;

  wire ext_rise;
  wire cell_rise;
  wire [`NOC_HF_PH_W-1:0] hf_sum;
  wire tick;
  wire [20:0] acc_sum;
  wire carry;
  wire wr_ctl;
  wire wr_clk;
  wire final_level;
  reg src_tick;
  reg [7:0] rd_value;
  reg active_nxt;
  reg [6:0] pulse_cnt_nxt;

  // ==========================================
  // Input clock synchronisers, two stages each
  // Third flop per source only keeps the last level for edge detect
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ext_sync1_r <= 1'b0;
      ext_sync2_r <= 1'b0;
      ext_prev_r <= 1'b0;
      cell_sync1_r <= 1'b0;
      cell_sync2_r <= 1'b0;
      cell_prev_r <= 1'b0;
    end else begin
      ext_sync1_r <= external_clock_pin;
      ext_sync2_r <= ext_sync1_r;
      ext_prev_r <= ext_sync2_r;
      cell_sync1_r <= logic_cell_output;
      cell_sync2_r <= cell_sync1_r;
      cell_prev_r <= cell_sync2_r;
    end
  end

  // Rising edges seen after the second stage only
  assign ext_rise = ext_sync2_r & ~ext_prev_r;
  assign cell_rise = cell_sync2_r & ~cell_prev_r;

  // ==========================================
  // Fast oscillator stand-in: fractional divider
  // Averages 16 ticks per 100 cycles; jitter of one cycle is the trade-off
  assign hf_sum = hf_phase_r + `NOC_HF_MHZ;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hf_phase_r <= {`NOC_HF_PH_W{1'b0}};
      hf_tick_r <= 1'b0;
    end else if (hf_sum >= `NOC_SYS_MHZ) begin
      hf_phase_r <= hf_sum - `NOC_SYS_MHZ;
      hf_tick_r <= 1'b1;
    end else begin
      hf_phase_r <= hf_sum;
      hf_tick_r <= 1'b0;
    end
  end

  // ==========================================
  // Input clock selection
  // System source ticks every cycle; pin and cell give one-cycle edge pulses, fast a one-cycle divider tick
  always @* begin
    case (clock_source_select_r) // RULE2
      `NOC_CKS_EXTPIN: src_tick = ext_rise;
      `NOC_CKS_LCELL: src_tick = cell_rise;
      `NOC_CKS_SYS: src_tick = 1'b1;
      `NOC_CKS_HFOSC: src_tick = hf_tick_r;
      default: src_tick = 1'b0;
    endcase
  end

  // Disabled module sees no input clock at all
  assign tick = src_tick & module_enable_bit_r; // RULE12

  // ==========================================
  // Adder and overflow
  assign acc_sum = {1'b0, phase_accumulator_r} + {5'h00, phase_increment_r};
  assign carry = acc_sum[20];

  // ==========================================
  // Register write decode
  assign wr_ctl = noc_wr_hit(reg_wr, reg_addr, `NOC_OFS_CONTROL);
  assign wr_clk = noc_wr_hit(reg_wr, reg_addr, `NOC_OFS_CLKCFG);

  // Control and clock configuration, unused bits never stored
  // Zero reset leaves the block stopped with its pin released
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      module_enable_bit_r <= 1'b0; // RULE11
      pin_output_enable_r <= 1'b0;
      output_polarity_bit_r <= 1'b0;
      pulse_mode_select_r <= 1'b0;
      pulse_width_select_r <= 3'h0;
      clock_source_select_r <= 2'h0;
    end else begin
      if (wr_ctl) begin
        module_enable_bit_r <= reg_wdata[`NOC_CTL_EN_BIT]; // RULE12
        pin_output_enable_r <= reg_wdata[`NOC_CTL_OE_BIT]; // RULE12
        output_polarity_bit_r <= reg_wdata[`NOC_CTL_POL_BIT]; // RULE5
        pulse_mode_select_r <= reg_wdata[`NOC_CTL_PFM_BIT]; // RULE9
      end
      if (wr_clk) begin
        pulse_width_select_r <= reg_wdata[`NOC_CLK_PWS_HI:`NOC_CLK_PWS_LO];
        clock_source_select_r <= reg_wdata[`NOC_CLK_CKS_HI:`NOC_CLK_CKS_LO];
      end
    end
  end

  // ==========================================
  // Increment: applied directly, no shadow copy
  // A change while running may give one odd period
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_increment_r <= {2{`NOC_RST_BYTE}}; // RULE11
    end else if (reg_wr) begin
      if (reg_addr == `NOC_OFS_INC_LOW) begin
        phase_increment_r[7:0] <= reg_wdata;
      end
      if (reg_addr == `NOC_OFS_INC_HIGH) begin
        phase_increment_r[15:8] <= reg_wdata;
      end
    end
  end

  // ==========================================
  // Accumulator: a byte write overrides a tick in the same cycle
  // Bytes load one at a time, so a tick between two writes may carry;
  // clear the enable first when a clean load matters
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_accumulator_r <= `NOC_RST_ACC; // RULE11
    end else if (noc_wr_hit(reg_wr, reg_addr, `NOC_OFS_ACC_LOW)) begin
      phase_accumulator_r[7:0] <= reg_wdata; // RULE7
    end else if (noc_wr_hit(reg_wr, reg_addr, `NOC_OFS_ACC_HIGH)) begin
      phase_accumulator_r[15:8] <= reg_wdata; // RULE7
    end else if (noc_wr_hit(reg_wr, reg_addr, `NOC_OFS_ACC_UPPER)) begin
      phase_accumulator_r[19:16] <= reg_wdata[3:0];
    end else if (tick) begin
      phase_accumulator_r <= acc_sum[19:0]; // RULE8
    end
  end

  // ==========================================
  // Output shaping before polarity
  // Width beyond the overflow period simply restarts the count
  // Fixed duty mode holds the count clear, so the width field is inert
  // Pulsed mode reloads the count on every carry
  always @* begin
    active_nxt = active_r;
    pulse_cnt_nxt = pulse_cnt_r;
    if (tick) begin
      if (!pulse_mode_select_r) begin
        pulse_cnt_nxt = 7'h00; // RULE3
        if (carry) begin
          active_nxt = ~active_r; // RULE9
        end
      end else if (carry) begin
        active_nxt = 1'b1; // RULE9
        pulse_cnt_nxt = noc_pulse_last(pulse_width_select_r); // RULE1
      end else if (pulse_cnt_r != 7'h00) begin
        pulse_cnt_nxt = pulse_cnt_r - 7'h01; // RULE1
      end else begin
        active_nxt = 1'b0; // RULE1
      end
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      active_r <= 1'b0;
      pulse_cnt_r <= 7'h00;
    end else begin
      active_r <= active_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  // ==========================================
  // Polarity as the last stage
  assign final_level = active_nxt ^ output_polarity_bit_r; // RULE5

  // Outputs registered; pin released unless output enable is set
  // Pin data follows the output even while the pin is released
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      osc_out <= 1'b0;
      overflow_pulse <= 1'b0;
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      osc_out <= final_level;
      overflow_pulse <= tick & carry;
      pin_out <= final_level;
      pin_oe_n <= ~pin_output_enable_r; // RULE12
    end
  end

  // ==========================================
  // Read mux, unused bits forced to zero
  always @* begin
    case (reg_addr)
      `NOC_OFS_CONTROL: rd_value = {module_enable_bit_r, pin_output_enable_r, osc_out, // RULE10
        output_polarity_bit_r, 3'h0, pulse_mode_select_r}; // RULE6
      `NOC_OFS_CLKCFG: rd_value = {pulse_width_select_r, 3'h0, clock_source_select_r}; // RULE6
      `NOC_OFS_ACC_LOW: rd_value = phase_accumulator_r[7:0]; // RULE7
      `NOC_OFS_ACC_HIGH: rd_value = phase_accumulator_r[15:8]; // RULE7
      `NOC_OFS_ACC_UPPER: rd_value = {`NOC_RST_NIB, phase_accumulator_r[19:16]};
      `NOC_OFS_INC_LOW: rd_value = phase_increment_r[7:0];
      `NOC_OFS_INC_HIGH: rd_value = phase_increment_r[15:8];
      default: rd_value = `NOC_RST_BYTE;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `NOC_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rd_value;
    end else begin
      reg_rdata <= `NOC_RST_BYTE;
    end
  end

endmodule

// [rtl/noc_regs.vh]
// Purpose: Register map, field positions, reset values and timing for the oscillator control block
// Assumes: 8-bit register port, byte offsets
// Notes: Definitions only
`ifndef NOC_REGS_VH
`define NOC_REGS_VH

// ==========================================
// Register offsets
`define NOC_ADDR_W 8
`define NOC_OFS_CONTROL 8'h00
`define NOC_OFS_CLKCFG 8'h01
`define NOC_OFS_ACC_LOW 8'h02
`define NOC_OFS_ACC_HIGH 8'h03
`define NOC_OFS_ACC_UPPER 8'h04
`define NOC_OFS_INC_LOW 8'h05
`define NOC_OFS_INC_HIGH 8'h06

// ==========================================
// Control register fields
`define NOC_CTL_EN_BIT 7
`define NOC_CTL_OE_BIT 6
`define NOC_CTL_OUT_BIT 5
`define NOC_CTL_POL_BIT 4
`define NOC_CTL_PFM_BIT 0

// ==========================================
// Clock register fields
`define NOC_CLK_PWS_HI 7
`define NOC_CLK_PWS_LO 5
`define NOC_CLK_CKS_HI 1
`define NOC_CLK_CKS_LO 0

// ==========================================
// Clock source codes
`define NOC_CKS_HFOSC 2'h0
`define NOC_CKS_SYS 2'h1
`define NOC_CKS_LCELL 2'h2
`define NOC_CKS_EXTPIN 2'h3

// ==========================================
// Reset values
`define NOC_RST_BYTE 8'h00
`define NOC_RST_NIB 4'h0
`define NOC_RST_ACC 20'h00000

// ==========================================
// Timing: fast oscillator rate from the system rate
`define NOC_SYS_MHZ 7'd100
`define NOC_HF_MHZ 7'd16
`define NOC_HF_PH_W 7

`endif

// [bench/noc_chk_assertions.sv]
// Purpose: Port checker for the oscillator block
// Assumes: Offsets from the shared header
// Notes: A control shadow tells settled outputs from transients
`timescale 1ns/1ps
`include "noc_regs.vh"
module noc_chk (
  input wire sys_clk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire osc_out,
  input wire overflow_pulse,
  input wire pin_out,
  input wire pin_oe_n
);
  reg [7:0] ctl_r;
  reg [7:0] ctl_q_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========
  // Control shadow, delayed copy for settling
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_r <= 8'h00;
      ctl_q_r <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `NOC_OFS_CONTROL) ctl_r <= reg_wdata;
      ctl_q_r <= ctl_r;
    end
  end
  sequence s_quiet;
    ctl_r == ctl_q_r && $stable(ctl_q_r);
  endsequence
  sequence s_rd(a);
    $past(reg_rd) && $past(reg_addr) == a;
  endsequence
  property p_oe; s_quiet |-> pin_oe_n == !ctl_r[6]; endproperty
  property p_pin; pin_out == osc_out; endproperty
  property p_rd0; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_ctl; s_rd(`NOC_OFS_CONTROL) |-> (reg_rdata & 8'hdf) == (ctl_r & 8'hd1); endproperty
  property p_unm; $past(reg_rd) && $past(reg_addr) > `NOC_OFS_INC_HIGH |-> reg_rdata == 8'h00; endproperty
  property p_ovf; overflow_pulse |=> !overflow_pulse [*8]; endproperty
  property p_fdc; s_quiet ##0 !ctl_r[0] |-> $changed(osc_out) == overflow_pulse; endproperty
  property p_en; s_quiet ##0 !ctl_r[7] |-> !overflow_pulse && $stable(osc_out); endproperty
  a_oe: assert property (p_oe) else $error("pin enable off");
  a_pin: assert property (p_pin) else $error("pin data off");
  a_rd0: assert property (p_rd0) else $error("idle read data");
  a_ctl: assert property (p_ctl) else $error("control readback");
  a_unm: assert property (p_unm) else $error("unmapped read");
  a_ovf: assert property (p_ovf) else $error("overflow spacing");
  a_fdc: assert property (p_fdc) else $error("toggle off overflow");
  a_en: assert property (p_en) else $error("runs disabled");
endmodule
bind noc_core noc_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_out(osc_out), .overflow_pulse(overflow_pulse),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// [bench/noc_far.sv]
// Purpose: Far side: pin clock, cell output, pin wire
// Assumes: Clocks stand still while run is low
// Notes: Pin period 6, cell period 8 cycles
`timescale 1ns/1ps
module noc_far (
  input wire sys_clk,
  input wire run,
  input wire pin_out,
  input wire pin_oe_n,
  output reg ext_clk,
  output reg cell_out,
  output reg pin_level
);
  reg [1:0] e_r = 2'h0;
  reg [1:0] c_r = 2'h0;
  initial begin
    ext_clk = 1'b0;
    cell_out = 1'b0;
    pin_level = 1'b1;
  end
  // Distinct rates so a swapped source shows
  always @(posedge sys_clk) begin
    if (run) begin
      e_r <= (e_r == 2'h2) ? 2'h0 : e_r + 2'h1;
      c_r <= c_r + 2'h1;
      ext_clk <= (e_r == 2'h2) ? !ext_clk : ext_clk;
      cell_out <= (c_r == 2'h3) ? !cell_out : cell_out;
    end
    pin_level <= !pin_oe_n ? pin_out : !pin_level;
  end
endmodule

// [bench/numeric_osc_control_test.sv]
// Purpose: Self-checking bench for the oscillator block
// Assumes: 100 MHz clock, offsets from header
// Notes: Widths counted in sys_clk cycles
`timescale 1ns/1ps
`include "noc_regs.vh"
module numeric_osc_control_test;
  reg sys_clk = 1'b0;
  reg nrst = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg run = 1'b0;
  wire [7:0] reg_rdata;
  wire ext_clk, cell_out, osc_out, pin_out, pin_oe_n, pin_level;
  integer n_errors = 0;
  integer n_tests = 0;
  integer i;
  integer n;
  noc_core DUT (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_clock_pin(ext_clk), .logic_cell_output(cell_out),
    .osc_out(osc_out), .overflow_pulse(), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  noc_far u_far (.sys_clk(sys_clk), .run(run), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_clk(ext_clk),
    .cell_out(cell_out), .pin_level(pin_level));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========
  // Compare, bus and wait helpers
  task chk(input [63:0] w, input [7:0] e, input [7:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", w, e, g);
      end
    end
  endtask
  task chk_n(input [63:0] w, input integer e, input integer t, input integer g);
    begin
      n_tests = n_tests + 1;
      if (g < e - t || g > e + t) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s expected %0d seen %0d", w, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e, input [63:0] w);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(w, e, reg_rdata);
    end
  endtask
  task wait_lvl(input l);
    integer k;
    begin
      k = 0;
      #1;
      while (osc_out !== l) begin
        @(posedge sys_clk);
        #1;
        k = k + 1;
        if (k > 3000) begin
          n_errors = n_errors + 1;
          $display("[FAIL] wait expected %b seen %b", l, osc_out);
          end_of_test;
        end
      end
    end
  endtask
  // Cycles spent at level l after a fresh entry
  task width(input l);
    begin
      wait_lvl(!l);
      wait_lvl(l);
      n = 0;
      while (osc_out === l && n < 3000) begin
        @(posedge sys_clk);
        #1;
        n = n + 1;
      end
      if (n >= 3000) begin
        n_errors = n_errors + 1;
        $display("[FAIL] width expected below %0d seen %0d", 3000, n);
        end_of_test;
      end
    end
  endtask
  task end_of_test;
    begin
      $display("Tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ==========
  // Scenarios
  task t_regs;
    begin
      for (i = 0; i < 5; i = i + 1) rd(i[7:0], 8'h00, "rst");
      wr(`NOC_OFS_CONTROL, 8'hff);
      wr(`NOC_OFS_CLKCFG, 8'hff);
      rd(`NOC_OFS_CONTROL, 8'hf1, "ctl");
      rd(`NOC_OFS_CLKCFG, 8'he3, "clk");
      chk("pin", 8'h01, {6'h0, pin_oe_n, pin_level});
      wr(`NOC_OFS_ACC_LOW, 8'ha5);
      wr(`NOC_OFS_ACC_HIGH, 8'h5a);
      rd(`NOC_OFS_ACC_LOW, 8'ha5, "accl");
      rd(`NOC_OFS_ACC_HIGH, 8'h5a, "acch");
      wr(8'h07, 8'hff);
      rd(8'h07, 8'h00, "unmap");
      wr(`NOC_OFS_CONTROL, 8'h40);
      run <= 1'b1;
      wr(`NOC_OFS_INC_HIGH, 8'h80);
      wr(`NOC_OFS_CLKCFG, 8'h01);
      wr(`NOC_OFS_ACC_LOW, 8'h33);
      repeat (20) @(posedge sys_clk);
      rd(`NOC_OFS_ACC_LOW, 8'h33, "hold");
      rd(`NOC_OFS_ACC_HIGH, 8'h5a, "hold");
      rd(`NOC_OFS_ACC_UPPER, 8'h00, "hold");
      $display("Test regs done");
    end
  endtask
  // Code order: fast, system, cell, pin
  task t_src;
    begin
      wr(`NOC_OFS_CONTROL, 8'hc0);
      for (i = 0; i < 4; i = i + 1) begin
        wr(`NOC_OFS_CLKCFG, 8'he0 | i[7:0]);
        width(1'b1);
        chk_n("src", i == 0 ? 200 : i == 1 ? 32 : i == 2 ? 256 : 192, i == 0 ? 2 : 0, n);
      end
      $display("Test sources done");
    end
  endtask
  // Widths kept under the 32-tick period
  task t_pf;
    begin
      wr(`NOC_OFS_CONTROL, 8'hc1);
      for (i = 0; i < 5; i = i + 2) begin
        wr(`NOC_OFS_CLKCFG, {i[2:0], 5'h01});
        width(1'b1);
        chk_n("pulse", 1 << i, 0, n);
      end
      wr(`NOC_OFS_CONTROL, 8'hd1);
      width(1'b0);
      chk_n("pol", 16, 0, n);
      $display("Test pulses done");
    end
  endtask
  task t_rst;
    begin
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      chk("out", 8'h01, {6'h0, osc_out, pin_oe_n});
      for (i = 0; i < 5; i = i + 1) rd(i[7:0], 8'h00, "rst2");
      $display("Test reset done");
    end
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs;
    t_src;
    t_pf;
    t_rst;
    end_of_test;
  end
endmodule
